// file: verilog/isp_ctrl_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the control block sources
`ifndef ISP_CTRL_REGS_SVH
`define ISP_CTRL_REGS_SVH

// register byte addresses on the apb bus
`define OFS_PLD_CLOCK_GATE 8'h00
`define OFS_PLD_CONTROL_INPUT_GATE 8'h04
`define OFS_ISP_CONTROL 8'h08
`define OFS_BLOCK_STATUS 8'h0C

// reset values and writable masks
`define RST_GATE 8'h00
`define MASK_PLD_CLOCK_GATE 8'h30
`define MASK_PLD_CONTROL_INPUT_GATE 8'h7C

// pld_clock_gate fields
`define BIT_CLK_ARRAY_OFF 4
`define BIT_CLK_MCELL_OFF 5
// pld_control_input_gate: first of five consecutive blocking bits
`define BIT_CTL_FIRST 2

// isp_control fields
`define BIT_HOST_ISP_ENABLE 0
`define BIT_EXT_PUSH_PULL 1

// port c positions of the programming signals
`define PC_TMS 0
`define PC_TCK 1
`define PC_STATUS 3
`define PC_ERROR 4
`define PC_TDI 5
`define PC_TDO 6
`define PC_CTL_BIT7 7

// timing
`define CLK_PERIOD_NS 50
`define OPR_TIME_NS 200
`define OPR_CYCLES ((`OPR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CFG_LOAD_CYCLES 16

// instruction codes, arbitrary values
`define IR_BYPASS 8'hFF
`define IR_ISP_ENABLE 8'hA5
`define IR_ISP_ENABLE_EXT 8'hA6
`define IR_CAPTURE 8'h01

`endif

// file: verilog/isp_ctrl_pkg.sv
// types shared by the chip select, reset and programming control block
// assumes nothing beyond a systemverilog compiler
package isp_ctrl_pkg;

   typedef enum logic [3:0]
   {
      TAP_EXIT2_DR = 4'h0,
      TAP_EXIT1_DR = 4'h1,
      TAP_SHIFT_DR = 4'h2,
      TAP_PAUSE_DR = 4'h3,
      TAP_SEL_IR = 4'h4,
      TAP_UPDATE_DR = 4'h5,
      TAP_CAPTURE_DR = 4'h6,
      TAP_SEL_DR = 4'h7,
      TAP_EXIT2_IR = 4'h8,
      TAP_EXIT1_IR = 4'h9,
      TAP_SHIFT_IR = 4'hA,
      TAP_PAUSE_IR = 4'hB,
      TAP_IDLE = 4'hC,
      TAP_UPDATE_IR = 4'hD,
      TAP_CAPTURE_IR = 4'hE,
      TAP_RESET = 4'hF
   } tap_state_t;

endpackage

// file: verilog/sync_2ff.sv
// two-flop synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level or a clock far below i_clk
`timescale 1ns/100ps
module sync_2ff #(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // data
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta <= i_async;
         o_sync <= meta;
      end
   end

endmodule

// file: verilog/chip_select_reset_isp_ctrl.sv
// chip select, power gating, reset sequencing and programming pin control
// assumes an apb master on i_clk and pins arriving asynchronously
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "isp_ctrl_regs.svh"

// What this block does
// - chip select low enables flash and io
// - chip select high disables flash, saves power
// - clock gate bits block pld clock
// - bits two to six block control inputs
// - host strobes always reach flash array
// - extra ready delay before memory access
// - flash returns to read-array at power-up
// - short warm reset, same ready delay
// - macrocells cleared only by power-on reset
// - pld outputs valid through warm reset
// - programming enable ors three sources
// - tdo driven only after enabling command
// - pld input reclaims programming pins anytime
// - host enable bit cleared by reset
// - no boundary scan, stays in bypass
// - port c default programming pin map
// - status and error pins enabled together
// - error pin low on flash failure
// - status pin high in read mode
// - status pins open-drain by default
// - gating registers cleared only at power-up
module chip_select_reset_isp_ctrl
   import isp_ctrl_pkg::*;
#(
   parameter int IR_WIDTH = 8
)
(
   // clock and resets
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_por_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // pins
   input wire logic i_chip_select_n,
   input wire logic i_pld_clock_input,
   input wire logic i_host_write_strobe_n,
   input wire logic i_host_read_strobe_n,
   input wire logic i_control_strobe_two,
   input wire logic i_port_d_bit0_pin,
   input wire logic i_pld_isp_request,
   input wire logic [7:0] i_port_c_in,
   output logic [7:0] o_port_c_out,
   output logic [7:0] o_port_c_oe,
   // port c general io from port logic
   input wire logic [7:0] i_gpio_out,
   input wire logic [7:0] i_gpio_oe,
   // configuration and flash state
   input wire logic i_pin_cfg_isp,
   input wire logic i_flash_busy,
   input wire logic i_flash_error,
   // flash and pld side
   output logic o_flash_io_enable,
   output logic o_reduced_power,
   output logic o_flash_write_strobe_n,
   output logic o_flash_read_strobe_n,
   output logic o_flash_read_array,
   output logic o_pld_and_clock,
   output logic o_pld_mcell_clock,
   output logic [4:0] o_pld_ctl_inputs,
   output logic o_pld_out_valid,
   output logic o_macrocell_clear,
   output logic o_isp_active
);

   localparam int SYNC_W = 10;
   localparam int OPR_M1 = `OPR_CYCLES - 1;

   logic rst_any_n;
   logic [SYNC_W-1:0] sync_q;
   logic cs_n_s, clk_s, wr_s, rd_s, control_strobe_two_s, pd0_s, pc7_s, pld_req_s, tck_s, tms_s, tdi_s;
   logic tck_d, tck_rise, tck_fall;
   logic [7:0] pld_clock_gate, pld_control_input_gate, isp_control;
   logic ready, cfg_loaded, jtag_on, tdo_enabled, ext_enabled, ext_active;
   logic [7:0] opr_cnt, cfg_cnt;
   tap_state_t tap, next_tap;
   logic [IR_WIDTH-1:0] ir, ir_shift;
   logic bypass_bit, tdo_val;
   logic [7:0] rd_mux;
   logic bus_setup, bus_write;

   assign rst_any_n = i_rst_n & i_por_n;

   // tck sampled by i_clk, so pins see two flops before use
   sync_2ff #(.WIDTH(SYNC_W)) u_sync
   (
      .i_clk(i_clk),
      .i_rst_n(rst_any_n),
      .i_async({i_port_c_in[`PC_TDI], i_port_c_in[`PC_TMS], i_port_c_in[`PC_TCK],
                i_pld_isp_request, i_port_c_in[`PC_CTL_BIT7], i_port_d_bit0_pin,
                i_control_strobe_two, i_host_read_strobe_n, i_host_write_strobe_n,
                i_pld_clock_input}),
      .o_sync(sync_q)
   );

   assign {tdi_s, tms_s, tck_s, pld_req_s, pc7_s, pd0_s, control_strobe_two_s, rd_s, wr_s, clk_s} = sync_q;

   // chip select keeps its own pair so its idle level is deselected
   logic cs_meta;
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         cs_meta <= 1'b1;
         cs_n_s <= 1'b1;
      end
      else
      begin
         cs_meta <= i_chip_select_n;
         cs_n_s <= cs_meta;
      end
   end

   // ---------- apb slave ----------
   assign bus_setup = i_psel & ~i_penable & ~o_pready;
   assign bus_write = i_psel & i_penable & o_pready & i_pwrite;

   always_comb
   begin
      rd_mux = 8'h00;
      if (i_paddr == `OFS_PLD_CLOCK_GATE)
         rd_mux = pld_clock_gate;
      else if (i_paddr == `OFS_PLD_CONTROL_INPUT_GATE)
         rd_mux = pld_control_input_gate;
      else if (i_paddr == `OFS_ISP_CONTROL)
         rd_mux = isp_control;
      else if (i_paddr == `OFS_BLOCK_STATUS)
         rd_mux = {2'b00, ~cs_n_s, cfg_loaded, ext_enabled, tdo_enabled, jtag_on, ready};
   end

   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= bus_setup;
         if (bus_setup)
         begin
            o_prdata <= {24'h00_0000, rd_mux};
            o_pslverr <= (i_paddr != `OFS_PLD_CLOCK_GATE) &&
                         (i_paddr != `OFS_PLD_CONTROL_INPUT_GATE) &&
                         (i_paddr != `OFS_ISP_CONTROL) &&
                         (i_paddr != `OFS_BLOCK_STATUS);
         end
      end
   end

   // gating registers survive warm reset
   always_ff @(posedge i_clk or negedge i_por_n)
   begin
      if (!i_por_n)
      begin
         pld_clock_gate <= `RST_GATE;
         pld_control_input_gate <= `RST_GATE;
      end
      else if (bus_write && i_paddr == `OFS_PLD_CLOCK_GATE)
         pld_clock_gate <= i_pwdata[7:0] & `MASK_PLD_CLOCK_GATE;
      else if (bus_write && i_paddr == `OFS_PLD_CONTROL_INPUT_GATE)
         pld_control_input_gate <= i_pwdata[7:0] & `MASK_PLD_CONTROL_INPUT_GATE;
   end

   // host enable bit and drive mode, cleared by any reset
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
         isp_control <= 8'h00;
      else if (bus_write && i_paddr == `OFS_ISP_CONTROL)
         isp_control <= {6'h00, i_pwdata[1:0]};
   end

   // ---------- reset sequencing ----------
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         opr_cnt <= 8'h00;
         ready <= 1'b0;
      end
      else if (!ready)
      begin
         opr_cnt <= opr_cnt + 8'h01;
         if (opr_cnt == 8'(OPR_M1))
            ready <= 1'b1;
      end
   end

   // configuration load runs only after power-on reset
   always_ff @(posedge i_clk or negedge i_por_n)
   begin
      if (!i_por_n)
      begin
         cfg_cnt <= 8'h00;
         cfg_loaded <= 1'b0;
      end
      else if (!cfg_loaded)
      begin
         cfg_cnt <= cfg_cnt + 8'h01;
         if (cfg_cnt == 8'(`CFG_LOAD_CYCLES - 1))
            cfg_loaded <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_por_n)
   begin
      if (!i_por_n)
      begin
         o_pld_out_valid <= 1'b0;
         o_macrocell_clear <= 1'b1;
         o_flash_read_array <= 1'b1;
      end
      else
      begin
         o_pld_out_valid <= cfg_loaded;
         o_macrocell_clear <= ~cfg_loaded;
         o_flash_read_array <= ~cfg_loaded;
      end
   end

   // ---------- chip select and gating ----------
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         o_flash_io_enable <= 1'b0;
         o_reduced_power <= 1'b1;
         o_flash_write_strobe_n <= 1'b1;
         o_flash_read_strobe_n <= 1'b1;
      end
      else
      begin
         o_flash_io_enable <= ~cs_n_s & ready;
         o_reduced_power <= cs_n_s;
         o_flash_write_strobe_n <= wr_s;
         o_flash_read_strobe_n <= rd_s;
      end
   end

   // pld inputs keep running regardless of chip select
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         o_pld_and_clock <= 1'b0;
         o_pld_mcell_clock <= 1'b0;
         o_pld_ctl_inputs <= 5'h00;
      end
      else
      begin
         o_pld_and_clock <= clk_s & ~pld_clock_gate[`BIT_CLK_ARRAY_OFF];
         o_pld_mcell_clock <= clk_s & ~pld_clock_gate[`BIT_CLK_MCELL_OFF];
         o_pld_ctl_inputs <= {pc7_s, pd0_s, control_strobe_two_s, ~rd_s, ~wr_s} &
                             ~pld_control_input_gate[`BIT_CTL_FIRST +: 5];
      end
   end

   // ---------- programming port ----------
   assign jtag_on = i_pin_cfg_isp | pld_req_s | isp_control[`BIT_HOST_ISP_ENABLE];
   assign ext_active = jtag_on & ext_enabled;

   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
         tck_d <= 1'b0;
      else
         tck_d <= tck_s;
   end

   assign tck_rise = jtag_on & tck_s & ~tck_d;
   assign tck_fall = jtag_on & ~tck_s & tck_d;

   always_comb
   begin
      next_tap = tap;
      case (tap)
         TAP_RESET: next_tap = tms_s ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAPTURE_DR;
         TAP_CAPTURE_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: next_tap = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: next_tap = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: next_tap = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
         TAP_UPDATE_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_tap = tms_s ? TAP_RESET : TAP_CAPTURE_IR;
         TAP_CAPTURE_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: next_tap = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: next_tap = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: next_tap = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
         TAP_UPDATE_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
         default: next_tap = TAP_RESET;
      endcase
   end

   // controller state and registers move on tck rising edges
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         tap <= TAP_RESET;
         ir <= `IR_BYPASS;
         ir_shift <= `IR_BYPASS;
         bypass_bit <= 1'b0;
      end
      else if (!jtag_on)
      begin
         tap <= TAP_RESET;
         ir <= `IR_BYPASS;
      end
      else if (tck_rise)
      begin
         tap <= next_tap;
         if (tap == TAP_RESET)
            ir <= `IR_BYPASS;
         if (tap == TAP_CAPTURE_IR)
            ir_shift <= `IR_CAPTURE;
         else if (tap == TAP_SHIFT_IR)
            ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]};
         if (tap == TAP_UPDATE_IR)
            ir <= ir_shift;
         // every instruction selects the one-bit bypass path
         if (tap == TAP_CAPTURE_DR)
            bypass_bit <= 1'b0;
         else if (tap == TAP_SHIFT_DR)
            bypass_bit <= tdi_s;
      end
   end

   // enabling command, optionally with the extension pair
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         tdo_enabled <= 1'b0;
         ext_enabled <= 1'b0;
      end
      else if (!jtag_on)
      begin
         tdo_enabled <= 1'b0;
         ext_enabled <= 1'b0;
      end
      else if (tck_rise && tap == TAP_UPDATE_IR)
      begin
         if (ir_shift == `IR_ISP_ENABLE)
            tdo_enabled <= 1'b1;
         else if (ir_shift == `IR_ISP_ENABLE_EXT)
         begin
            tdo_enabled <= 1'b1;
            ext_enabled <= 1'b1;
         end
      end
   end

   // tdo changes on tck falling edge
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
         tdo_val <= 1'b0;
      else if (tck_fall)
         tdo_val <= (tap == TAP_SHIFT_IR) ? ir_shift[0] : bypass_bit;
   end

   // port c pin drive: programming map overrides general io
   always_ff @(posedge i_clk or negedge rst_any_n)
   begin
      if (!rst_any_n)
      begin
         o_port_c_out <= 8'h00;
         o_port_c_oe <= 8'h00;
         o_isp_active <= 1'b0;
      end
      else
      begin
         o_isp_active <= jtag_on;
         o_port_c_out <= i_gpio_out;
         o_port_c_oe <= i_gpio_oe;
         if (jtag_on)
         begin
            o_port_c_oe[`PC_TMS] <= 1'b0;
            o_port_c_oe[`PC_TCK] <= 1'b0;
            o_port_c_oe[`PC_TDI] <= 1'b0;
            o_port_c_out[`PC_TDO] <= tdo_val;
            o_port_c_oe[`PC_TDO] <= tdo_enabled &&
                                    (tap == TAP_SHIFT_DR || tap == TAP_SHIFT_IR);
         end
         if (ext_active)
         begin
            if (isp_control[`BIT_EXT_PUSH_PULL])
            begin
               o_port_c_out[`PC_STATUS] <= ~i_flash_busy;
               o_port_c_oe[`PC_STATUS] <= 1'b1;
               o_port_c_out[`PC_ERROR] <= ~i_flash_error;
               o_port_c_oe[`PC_ERROR] <= 1'b1;
            end
            else
            begin
               o_port_c_out[`PC_STATUS] <= 1'b0;
               o_port_c_oe[`PC_STATUS] <= i_flash_busy;
               o_port_c_out[`PC_ERROR] <= 1'b0;
               o_port_c_oe[`PC_ERROR] <= i_flash_error;
            end
         end
      end
   end

   // ---------- assertions ----------
   sequence seq_enable_cmd;
      jtag_on && tck_rise && tap == TAP_UPDATE_IR && ir_shift == `IR_ISP_ENABLE_EXT;
   endsequence

   sequence seq_pair_on;
      tdo_enabled && ext_enabled;
   endsequence

   AST_DESELECT_OFF: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      cs_n_s |=> !o_flash_io_enable && o_reduced_power)
      else $error("flash left enabled while deselected");

   AST_SELECT_ON: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      (!cs_n_s && ready) |=> o_flash_io_enable)
      else $error("flash not enabled while selected");

   AST_NOT_READY_BLOCKS: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      !ready |=> !o_flash_io_enable)
      else $error("access enabled before ready delay");

   AST_READY_DELAY: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      $rose(ready) |-> $past(opr_cnt) == 8'(OPR_M1))
      else $error("ready delay length wrong");

   AST_ARRAY_CLOCK_GATE: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      pld_clock_gate[`BIT_CLK_ARRAY_OFF] |=> !o_pld_and_clock)
      else $error("pld clock reached and array while blocked");

   AST_CTL_GATE: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      pld_control_input_gate[`BIT_CTL_FIRST + 4] |=> !o_pld_ctl_inputs[4])
      else $error("port c bit7 reached and array while blocked");

   AST_STROBE_PASSES: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      pld_control_input_gate[`BIT_CTL_FIRST] |=> o_flash_write_strobe_n == $past(wr_s))
      else $error("write strobe blocked from flash");

   AST_TDO_AFTER_CMD: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      o_port_c_oe[`PC_TDO] && o_isp_active |-> $past(tdo_enabled))
      else $error("tdo driven before enabling command");

   AST_PAIR_ENABLE: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      seq_enable_cmd |=> seq_pair_on)
      else $error("extension pair not enabled by command");

   AST_BUSY_LOW: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      (ext_active && i_flash_busy) |=> o_port_c_oe[`PC_STATUS] && !o_port_c_out[`PC_STATUS])
      else $error("status pin not low while busy");

   AST_ERROR_LOW: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      (ext_active && i_flash_error) |=> o_port_c_oe[`PC_ERROR] && !o_port_c_out[`PC_ERROR])
      else $error("error pin not low on failure");

   AST_RESET_BYPASS: assert property (@(posedge i_clk) disable iff (!rst_any_n)
      (jtag_on && tck_rise && tap == TAP_RESET) |=> ir == `IR_BYPASS)
      else $error("instruction not bypass after controller reset");

endmodule

// file: verif/jtag_host_model.sv
// programming controller model driving tck, tms and tdi
// assumes the bench builds port c from these and pulled-up pads
`timescale 1ns/100ps
module jtag_host_model
(
   // clock
   input wire logic i_clk,
   // pins
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi
);
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end

   // one tck period of 8 clocks, tck stands low between frames
   task automatic step(input logic m, input logic d);
      @(posedge i_clk);
      o_tms <= m;
      o_tdi <= d;
      repeat (3) @(posedge i_clk);
      o_tck <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_tck <= 1'b0;
   endtask

   // tap reset, shift an instruction lsb first, back to idle
   task automatic load_ir(input logic [7:0] code);
      repeat (5) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < 8; i++)
         step(i == 7, code[i]);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
endmodule

// file: verif/chip_select_reset_isp_ctrl_test.sv
// self-checking bench for the chip select, reset and programming block
// assumes apb zero wait states and pins synchronised in 3 clocks
`timescale 1ns/100ps
`include "isp_ctrl_regs.svh"
module chip_select_reset_isp_ctrl_test;
   logic clk, rst_n, por_n, psel, penable, pwrite, cs_n, clk_pin, wr_n, rd_n;
   logic control_strobe_two, pd0, pc7, isp_req, cfg, busy, err, serr, pready, pslverr;
   logic fio, rpow, fwr_n, frd_n, frarr, andclk, mcclk, oval, mclr, isp;
   logic tck, tms, tdi;
   logic [4:0] ctl;
   logic [7:0] paddr, g, pc_out, pc_oe;
   logic [31:0] pwdata, prdata, q;
   int num_errors = 0;
   int num_checks = 0;
   // port c pads with pull-ups
   wire [7:0] pad = (pc_oe & pc_out) | ~pc_oe;

   chip_select_reset_isp_ctrl chip_select_reset_isp_ctrl_inst
   (
      .i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_chip_select_n(cs_n), .i_pld_clock_input(clk_pin),
      .i_host_write_strobe_n(wr_n), .i_host_read_strobe_n(rd_n),
      .i_control_strobe_two(control_strobe_two), .i_port_d_bit0_pin(pd0), .i_pld_isp_request(isp_req),
      .i_port_c_in({pc7, pad[6], tdi, pad[4:2], tck, tms}),
      .o_port_c_out(pc_out), .o_port_c_oe(pc_oe),
      .i_gpio_out(8'hAA), .i_gpio_oe(8'hFF),
      .i_pin_cfg_isp(cfg), .i_flash_busy(busy), .i_flash_error(err),
      .o_flash_io_enable(fio), .o_reduced_power(rpow), .o_flash_write_strobe_n(fwr_n),
      .o_flash_read_strobe_n(frd_n), .o_flash_read_array(frarr), .o_pld_and_clock(andclk),
      .o_pld_mcell_clock(mcclk), .o_pld_ctl_inputs(ctl), .o_pld_out_valid(oval),
      .o_macrocell_clear(mclr), .o_isp_active(isp)
   );

   jtag_host_model jtag_host_model_inst
   (
      .i_clk(clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // n rising edges, then look at settled outputs
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial
   begin
      #200000;
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      por_n = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cs_n = 1'b0;
      clk_pin = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      {control_strobe_two, pd0, pc7, isp_req, cfg, busy, err} = 7'h00;
      settle(5);
      chk({frarr, mclr, fio}, 3'b110);
      @(posedge clk);
      por_n <= 1'b1;
      rst_n <= 1'b1;
      settle(2);
      chk(fio, 1'b0);
      settle(20);
      chk({fio, rpow, oval, mclr}, 4'b1010);
      $display("power-on test done");
      apb(0, `OFS_PLD_CLOCK_GATE, 0);
      chk(q, 32'h0);
      apb(0, `OFS_PLD_CONTROL_INPUT_GATE, 0);
      chk(q, 32'h0);
      apb(0, 8'h10, 0);
      chk({serr, q[7:0]}, 9'h100);
      @(posedge clk);
      {wr_n, rd_n, control_strobe_two, pd0, pc7} <= 5'b00111;
      for (int i = 0; i < 6; i++)
      begin
         g = (i < 5) ? (8'h04 << i) : 8'hFF;
         apb(1, `OFS_PLD_CONTROL_INPUT_GATE, {24'h0, g});
         settle(4);
         chk(ctl, 5'(~g[6:2]));
         chk({fwr_n, frd_n}, 2'b00);
      end
      apb(0, `OFS_PLD_CONTROL_INPUT_GATE, 0);
      chk(q, 32'h7C);
      for (int i = 0; i < 4; i++)
      begin
         g = 8'(i << 4);
         apb(1, `OFS_PLD_CLOCK_GATE, {24'h0, g});
         settle(4);
         chk({andclk, mcclk}, {~g[4], ~g[5]});
      end
      $display("gating test done");
      @(posedge clk);
      cs_n <= 1'b1;
      settle(4);
      chk({fio, rpow, pc_oe}, 10'h1FF);
      @(posedge clk);
      cs_n <= 1'b0;
      settle(4);
      chk({fio, rpow}, 2'b10);
      for (int s = 0; s < 4; s++)
      begin
         @(posedge clk);
         cfg <= (s == 1);
         isp_req <= (s == 2);
         apb(1, `OFS_ISP_CONTROL, {31'h0, s == 3});
         settle(4);
         chk(isp, s != 0);
      end
      apb(0, `OFS_BLOCK_STATUS, 0);
      chk({q[3:2], pc_oe & 8'h23}, 10'h000);
      jtag_host_model_inst.load_ir(`IR_ISP_ENABLE);
      apb(0, `OFS_BLOCK_STATUS, 0);
      chk(q[3:1], 3'b011);
      jtag_host_model_inst.load_ir(`IR_ISP_ENABLE_EXT);
      apb(0, `OFS_BLOCK_STATUS, 0);
      chk({q[3:1], pc_oe[6]}, 4'hE);
      @(posedge clk);
      busy <= 1'b1;
      settle(3);
      chk({pc_oe[3], pc_out[3]}, 2'b10);
      @(posedge clk);
      busy <= 1'b0;
      settle(3);
      chk({pc_oe[3], pad[3]}, 2'b01);
      @(posedge clk);
      err <= 1'b1;
      settle(3);
      chk({pc_oe[4], pc_out[4]}, 2'b10);
      apb(1, `OFS_ISP_CONTROL, 32'h3);
      @(posedge clk);
      err <= 1'b0;
      settle(3);
      chk({pc_oe[4], pc_out[4]}, 2'b11);
      $display("programming test done");
      @(posedge clk);
      rst_n <= 1'b0;
      settle(2);
      chk({oval, mclr, fio}, 3'b100);
      @(posedge clk);
      rst_n <= 1'b1;
      settle(2);
      chk(fio, 1'b0);
      settle(8);
      chk(fio, 1'b1);
      apb(0, `OFS_PLD_CLOCK_GATE, 0);
      chk(q, 32'h30);
      apb(0, `OFS_PLD_CONTROL_INPUT_GATE, 0);
      chk(q, 32'h7C);
      apb(0, `OFS_ISP_CONTROL, 0);
      chk(q, 32'h0);
      chk(isp, 1'b0);
      $display("warm reset test done");
      tally_and_finish();
   end
endmodule
